/* bench/lpm_wake_model.sv */
// Model of the wake sources: two external irq lines and a keypad line.
// Assumes one start pulse per wake; lines are levels held for a count.
module lpm_wake_model (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         start,
  input  wire logic [1:0]   sel,
  input  wire logic [11:0]  hold,
  input  wire logic         key_high,
  output lpm_pkg::lpm_wake_t wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] left_q;
  logic [1:0]  sel_q;
  logic        on;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      left_q <= 12'h000;
      sel_q <= 2'h0;
    end else if (start) begin
      left_q <= hold;
      sel_q <= sel;
    end else if (left_q != 12'h000) begin
      left_q <= left_q - 12'h001;
    end
  end
  // Lines stay asserted for the whole hold so the oscillator can settle.
  assign on = (left_q != 12'h000);
  assign wake.ext_irq_zero_input = on && (sel_q == 2'h0);
  assign wake.ext_irq_one_input = on && (sel_q == 2'h1);
  assign wake.keypad_wake_input = (on && sel_q == 2'h2) ? key_high : ~key_high;
endmodule // lpm_wake_model

/* bench/tb_lpm_ctrl.sv */
// Self-checking bench of the low-power mode controller.
// Assumes lpm_pkg and the wake model are compiled first.
module tb_lpm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic reset_pin = 1'b0;
  logic mode_write = 1'b0;
  logic [1:0] mode_wdata = 2'h0;
  logic idle_irq = 1'b0;
  logic kp_high = 1'b1;
  logic start = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [11:0] hold = 12'h000;
  lpm_pkg::lpm_wake_t wake;
  lpm_pkg::lpm_gate_t gate;
  logic idle_bit, pd_bit, isr, irst, sfrr;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  lpm_ctrl lpm_ctrl_inst (.clock(clock), .resetn(resetn), .reset_pin(reset_pin),
    .mode_write(mode_write), .mode_wdata(mode_wdata), .idle_irq(idle_irq),
    .wake_in(wake), .keypad_level_high(kp_high), .idle_request_bit(idle_bit),
    .powerdown_request_bit(pd_bit), .gate(gate), .isr_request(isr),
    .internal_reset(irst), .sfr_reset(sfrr));
  lpm_wake_model lpm_wake_model_inst (.clock(clock), .resetn(resetn), .start(start),
    .sel(sel), .hold(hold), .key_high(kp_high), .wake(wake));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The whole run needs about 2250 cycles; the ceiling leaves wide margin.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [1:0] d);
    @(posedge clock);
    mode_write <= 1'b1;
    mode_wdata <= d;
    @(posedge clock);
    mode_write <= 1'b0;
  endtask
  task automatic go(input logic [1:0] s, input logic [11:0] h);
    @(posedge clock);
    start <= 1'b1;
    sel <= s;
    hold <= h;
    @(posedge clock);
    start <= 1'b0;
  endtask
  task automatic wt(input int w, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((w == 0 ? isr : w == 1 ? irst : gate.cpu_clock_en) !== 1'b1 && n < 3000);
  endtask
  task automatic t_idle();
    int n;
    #1;
    chk({idle_bit, pd_bit, gate}, 7'h1f);
    wr(2'h1);
    repeat (2) @(posedge clock);
    #1;
    chk({idle_bit, gate[4:3]}, 3'h5);
    @(posedge clock);
    idle_irq <= 1'b1;
    wt(0, n);
    chk(idle_bit, 1'b0);
    @(posedge clock);
    idle_irq <= 1'b0;
    wt(2, n);
    chk(n < 3, 1'b1);
  endtask
  task automatic t_ext();
    int n;
    for (int s = 0; s < 2; s++) begin
      wr(2'h3);
      repeat (2) @(posedge clock);
      #1;
      chk({idle_bit, pd_bit, gate[4:2]}, 5'h18);
      go(s[1:0], 12'h03c);
      repeat (10) @(posedge clock);
      #1;
      chk({pd_bit, gate.cpu_clock_en}, 2'h0);
      wt(0, n);
      chk(n > 45, 1'b1);
      repeat (2) @(posedge clock);
      #1;
      chk({idle_bit, gate}, 6'h1f);
    end
  endtask
  task automatic t_key();
    int n;
    @(posedge clock);
    kp_high <= 1'b0;
    wr(2'h2);
    idle_irq <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk(pd_bit, 1'b1);
    @(posedge clock);
    idle_irq <= 1'b0;
    go(2'h2, 12'h07d0);
    wt(2, n);
    chk(n >= 1024 && n < 1040, 1'b1);
    chk(wake.keypad_wake_input, 1'b0);
    repeat (1000) @(posedge clock);
    #1;
    chk(wake.keypad_wake_input, 1'b1);
  endtask
  task automatic t_rst();
    int n;
    for (int d = 1; d < 3; d++) begin
      wr(d[1:0]);
      repeat (3) @(posedge clock);
      reset_pin <= 1'b1;
      #1;
      chk({idle_bit, pd_bit}, 2'h0);
      repeat (3) @(posedge clock);
      #1;
      chk({gate.cpu_clock_en, gate.ram_access_en, gate.port_access_en}, 3'h5);
      wt(1, n);
      chk({sfrr, n < 8}, 2'h3);
      @(posedge clock);
      reset_pin <= 1'b0;
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_idle();
    t_ext();
    t_key();
    t_rst();
    conclude();
  end
endmodule // tb_lpm_ctrl

/* inc/lpm_ctrl_regs.svh */
// Constants of the low-power mode controller: config bit positions, reset values, counts.
// Assumes a 100 MHz system clock standing in for the oscillator clock.
`ifndef LPM_CTRL_REGS_SVH
`define LPM_CTRL_REGS_SVH

`define LPM_IDLE_BIT        0
`define LPM_PDOWN_BIT       1
`define LPM_MODE_RESET      2'h0
`define LPM_KEY_WAKE_CLOCKS 11'h0400
`define LPM_RESET_TAKEOVER  4'h4

`endif

/* inc/lpm_pkg.sv */
// Types of the low-power mode controller.
// Assumes lpm_ctrl_regs.svh is included by the design file.
package lpm_pkg;

  typedef enum logic [2:0] {
    LPM_RUN        = 3'b000,
    LPM_IDLE       = 3'b001,
    LPM_PDOWN      = 3'b010,
    LPM_WAIT_EXT   = 3'b011,
    LPM_WAIT_KEY   = 3'b100,
    LPM_RST_RESUME = 3'b101
  } lpm_state_t;

  typedef struct packed {
    logic ext_irq_zero_input;
    logic ext_irq_one_input;
    logic keypad_wake_input;
  } lpm_wake_t;

  typedef struct packed {
    logic cpu_clock_en;
    logic periph_clock_en;
    logic osc_enable;
    logic ram_access_en;
    logic port_access_en;
  } lpm_gate_t;

endpackage

/* verilog/lpm_ctrl.sv */
// Low-power mode sequencer: Idle and Power-down entry, wake and reset exit.
// Assumes the CPU core writes the mode bits at instruction end and honours the gate outputs.
// Function
// [RQ1] Idle entered right after setting instruction
// [RQ2] Idle gates CPU clock, peripherals keep running
// [RQ3] Enabled interrupt clears idle, restores CPU clock
// [RQ4] Both bits set: Power-down only, no Idle
// [RQ5] Reset pin clears idle bit asynchronously
// [RQ6] Brief resume then reset restarts at zero
// [RQ7] Resume window blocks RAM, allows ports
// [RQ8] Software avoids port write after entry
// [RQ9] Power-down stops oscillator, freezes all clocks
// [RQ10] Power-down keeps CPU state and RAM
// [RQ11] Power-down entered right after setting instruction
// [RQ12] Only two external and keypad inputs wake
// [RQ13] Wake clears power-down bit, restarts all clocks
// [RQ14] External wake holds CPU until input released
// [RQ15] Keypad wake waits 1024 clocks before resume
// [RQ16] Wake runs service routine, then continues
// [RQ17] Software makes wake interrupt level, highest priority
// [RQ18] Keypad wake level selectable high or low
// [RQ19] Reset pin clears power-down bit, restarts clocks
// [RQ20] Power-down reset exit restarts at zero
// [RQ21] Reset exit resets registers, keeps RAM
// [RQ22] Interrupt wake keeps registers and RAM
// [RQ23] Fixed cycle count before reset takes over

`include "lpm_ctrl_regs.svh"

module lpm_ctrl (
  input  wire logic            clock,
  input  wire logic            resetn,
  input  wire logic            reset_pin,
  input  wire logic            mode_write,
  input  wire logic [1:0]      mode_wdata,
  input  wire logic            idle_irq,
  input  wire lpm_pkg::lpm_wake_t wake_in,
  input  wire logic            keypad_level_high,
  output logic                 idle_request_bit,
  output logic                 powerdown_request_bit,
  output lpm_pkg::lpm_gate_t   gate,
  output logic                 isr_request,
  output logic                 internal_reset,
  output logic                 sfr_reset
);

  // ************************************************************
  // Wake decode
  // ************************************************************

  lpm_pkg::lpm_state_t state_q;
  logic [10:0]         key_cnt_q;
  logic [3:0]          take_cnt_q;
  logic                ext_wake;
  logic                key_wake;
  logic                rst_hit_q;

  function automatic logic key_active(input logic lvl, input logic high);
    key_active = high ? lvl : ~lvl;
  endfunction

  // Only these three sources and the reset pin may end Power-down; others are not even looked at.
  assign ext_wake = wake_in.ext_irq_zero_input | wake_in.ext_irq_one_input; // RQ12
  assign key_wake = key_active(wake_in.keypad_wake_input, keypad_level_high); // RQ18

  // ************************************************************
  // Mode bits
  // ************************************************************

  // The reset pin clears both bits with no clock edge; this is the one asynchronous path.
  always_ff @(posedge clock or posedge reset_pin) begin
    if (reset_pin) begin
      idle_request_bit      <= 1'b0; // RQ5
      powerdown_request_bit <= 1'b0; // RQ19
    end else if (!resetn) begin
      idle_request_bit      <= 1'b0;
      powerdown_request_bit <= 1'b0;
    end else if (mode_write) begin
      idle_request_bit      <= mode_wdata[`LPM_IDLE_BIT];
      powerdown_request_bit <= mode_wdata[`LPM_PDOWN_BIT];
    end else if (state_q == lpm_pkg::LPM_IDLE && idle_irq) begin
      idle_request_bit <= 1'b0; // RQ3
    end else if (state_q == lpm_pkg::LPM_PDOWN && (ext_wake || key_wake)) begin
      powerdown_request_bit <= 1'b0; // RQ13
      idle_request_bit      <= 1'b0; // RQ4
    end
  end

  // Reset pin seen synchronously for sequencing; the async clear above already acted.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rst_hit_q <= 1'b0;
    end else begin
      rst_hit_q <= reset_pin;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= lpm_pkg::LPM_RUN;
    end else if (rst_hit_q && (state_q == lpm_pkg::LPM_IDLE || state_q == lpm_pkg::LPM_PDOWN)) begin
      state_q <= lpm_pkg::LPM_RST_RESUME; // RQ6 RQ20
    end else begin
      unique case (state_q)
        lpm_pkg::LPM_RUN: begin
          if (mode_write && mode_wdata[`LPM_PDOWN_BIT]) begin
            state_q <= lpm_pkg::LPM_PDOWN; // RQ11 RQ4
          end else if (mode_write && mode_wdata[`LPM_IDLE_BIT]) begin
            state_q <= lpm_pkg::LPM_IDLE; // RQ1
          end
        end
        lpm_pkg::LPM_IDLE: begin
          if (idle_irq) begin
            state_q <= lpm_pkg::LPM_RUN; // RQ3
          end
        end
        lpm_pkg::LPM_PDOWN: begin
          if (ext_wake) begin
            state_q <= lpm_pkg::LPM_WAIT_EXT;
          end else if (key_wake) begin
            state_q <= lpm_pkg::LPM_WAIT_KEY;
          end
        end
        lpm_pkg::LPM_WAIT_EXT: begin
          if (!ext_wake) begin
            state_q <= lpm_pkg::LPM_RUN; // RQ14
          end
        end
        lpm_pkg::LPM_WAIT_KEY: begin
          if (key_cnt_q == `LPM_KEY_WAKE_CLOCKS - 11'h0001) begin
            state_q <= lpm_pkg::LPM_RUN; // RQ15
          end
        end
        lpm_pkg::LPM_RST_RESUME: begin
          if (take_cnt_q == `LPM_RESET_TAKEOVER - 4'h1) begin
            state_q <= lpm_pkg::LPM_RUN; // RQ23
          end
        end
        default: state_q <= lpm_pkg::LPM_RUN;
      endcase
    end
  end

  // Keypad wake counts oscillator clocks, key level is ignored meanwhile.
  always_ff @(posedge clock) begin
    if (!resetn || state_q != lpm_pkg::LPM_WAIT_KEY) begin
      key_cnt_q <= 11'h0000;
    end else begin
      key_cnt_q <= key_cnt_q + 11'h0001; // RQ15
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || state_q != lpm_pkg::LPM_RST_RESUME) begin
      take_cnt_q <= 4'h0;
    end else begin
      take_cnt_q <= take_cnt_q + 4'h1; // RQ23
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  always_ff @(posedge clock) begin
    if (!resetn) begin
      gate           <= 5'b1_1111;
      isr_request    <= 1'b0;
      internal_reset <= 1'b0;
      sfr_reset      <= 1'b0;
    end else begin
      // CPU clock stops in Idle and every Power-down step; peripherals only in Power-down.
      gate.cpu_clock_en    <= (state_q == lpm_pkg::LPM_RUN) ||
                              (state_q == lpm_pkg::LPM_RST_RESUME); // RQ2 RQ10 RQ14
      gate.periph_clock_en <= (state_q != lpm_pkg::LPM_PDOWN); // RQ9 RQ13
      gate.osc_enable      <= (state_q != lpm_pkg::LPM_PDOWN); // RQ9 RQ13
      // Instructions resumed after a reset exit may touch ports, never internal RAM.
      gate.ram_access_en   <= (state_q != lpm_pkg::LPM_RST_RESUME); // RQ7 RQ21
      gate.port_access_en  <= 1'b1; // RQ7
      isr_request <= (state_q == lpm_pkg::LPM_IDLE && idle_irq && !rst_hit_q) ||
                     (state_q == lpm_pkg::LPM_WAIT_EXT && !ext_wake) ||
                     (state_q == lpm_pkg::LPM_WAIT_KEY &&
                      key_cnt_q == `LPM_KEY_WAKE_CLOCKS - 11'h0001); // RQ16 RQ22
      internal_reset <= (state_q == lpm_pkg::LPM_RST_RESUME) &&
                        (take_cnt_q == `LPM_RESET_TAKEOVER - 4'h1); // RQ6 RQ20
      sfr_reset      <= (state_q == lpm_pkg::LPM_RST_RESUME) &&
                        (take_cnt_q == `LPM_RESET_TAKEOVER - 4'h1); // RQ21
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  a_idle_entry_gate: assert property (@(posedge clock) disable iff (!resetn) // RQ1
    (state_q == lpm_pkg::LPM_RUN && mode_write && mode_wdata == 2'b01)
      |-> ##2 !gate.cpu_clock_en && gate.periph_clock_en)
    else $error("idle entry did not gate cpu clock");

  a_both_bits_pdown: assert property (@(posedge clock) disable iff (!resetn) // RQ4
    (state_q == lpm_pkg::LPM_RUN && mode_write && mode_wdata == 2'b11)
      |=> state_q == lpm_pkg::LPM_PDOWN)
    else $error("both bits did not select power-down");

  a_pdown_osc_off: assert property (@(posedge clock) disable iff (!resetn) // RQ9
    state_q == lpm_pkg::LPM_PDOWN |=> !gate.osc_enable && !gate.periph_clock_en)
    else $error("oscillator not stopped in power-down");

  a_idle_irq_clear: assert property (@(posedge clock) disable iff (!resetn || reset_pin) // RQ3
    (state_q == lpm_pkg::LPM_IDLE && idle_irq && !mode_write && !rst_hit_q)
      |=> !idle_request_bit ##1 gate.cpu_clock_en)
    else $error("idle interrupt exit failed");

  a_ext_hold_cpu: assert property (@(posedge clock) disable iff (!resetn || reset_pin) // RQ14
    (state_q == lpm_pkg::LPM_WAIT_EXT && ext_wake) |=> ##1 !gate.cpu_clock_en)
    else $error("cpu ran while external wake held");

  // Dwell counter for the keypad checks, kept apart from the sequencer's own counter
  // so that a fault in that counter cannot hide behind itself.
  logic [10:0] key_dwell_q;

  always_ff @(posedge clock) begin
    if (!resetn || state_q != lpm_pkg::LPM_WAIT_KEY) begin
      key_dwell_q <= 11'h000;
    end else begin
      key_dwell_q <= key_dwell_q + 11'h001;
    end
  end

  a_key_wait_entry: assert property (@(posedge clock) disable iff (!resetn || reset_pin) // RQ18
    (state_q == lpm_pkg::LPM_PDOWN && !ext_wake && !rst_hit_q &&
     wake_in.keypad_wake_input == keypad_level_high)
      |=> state_q == lpm_pkg::LPM_WAIT_KEY)
    else $error("keypad level did not start the wake count");

  a_key_wait_hold: assert property (@(posedge clock) disable iff (!resetn) // RQ15
    (state_q == lpm_pkg::LPM_WAIT_KEY && key_dwell_q != `LPM_KEY_WAKE_CLOCKS - 11'h001)
      |=> state_q == lpm_pkg::LPM_WAIT_KEY)
    else $error("keypad wait ended early");

  a_key_wait_end: assert property (@(posedge clock) disable iff (!resetn) // RQ15
    (state_q == lpm_pkg::LPM_WAIT_KEY && key_dwell_q == `LPM_KEY_WAKE_CLOCKS - 11'h001)
      |=> state_q == lpm_pkg::LPM_RUN && isr_request)
    else $error("keypad wait did not end after its count");

  a_resume_no_ram: assert property (@(posedge clock) disable iff (!resetn) // RQ7
    $past(state_q) == lpm_pkg::LPM_RST_RESUME |-> !gate.ram_access_en && gate.port_access_en)
    else $error("ram open during reset resume");

  a_takeover_delay: assert property (@(posedge clock) disable iff (!resetn) // RQ23
    $rose(state_q == lpm_pkg::LPM_RST_RESUME) |-> ##4 internal_reset && sfr_reset)
    else $error("reset takeover delay wrong");

  // ************************************************************
  // Sequencing checks
  // ************************************************************

  // These watch the sequencer from outside: each names a state, a registered output or both, and
  // the cycle at which each must hold, so a one-cycle slip in the output stage shows.
  // The reset pin is excluded only where its asynchronous clear makes a bit unpredictable.

  a_pin_clears_bits: assert property (@(posedge clock) disable iff (!resetn) // RQ5
    reset_pin |-> !idle_request_bit && !powerdown_request_bit)
    else $error("mode bit survived the reset pin");

  a_idle_enter: assert property (@(posedge clock) disable iff (!resetn || reset_pin) // RQ1
    (state_q == lpm_pkg::LPM_RUN && mode_write && mode_wdata == 2'b01)
      |=> state_q == lpm_pkg::LPM_IDLE && idle_request_bit)
    else $error("idle request did not enter idle");

  a_idle_irq_exit: assert property (@(posedge clock) disable iff (!resetn) // RQ3
    (state_q == lpm_pkg::LPM_IDLE && idle_irq && !rst_hit_q)
      |=> state_q == lpm_pkg::LPM_RUN && isr_request)
    else $error("idle interrupt did not resume");

  a_pdown_entry: assert property (@(posedge clock) disable iff (!resetn || reset_pin) // RQ11
    (state_q == lpm_pkg::LPM_RUN && mode_write && mode_wdata == 2'b10)
      |=> state_q == lpm_pkg::LPM_PDOWN && powerdown_request_bit)
    else $error("power-down request did not enter power-down");

  a_pdown_ignores_irq: assert property (@(posedge clock) disable iff (!resetn) // RQ12
    (state_q == lpm_pkg::LPM_PDOWN && !ext_wake && !key_wake && !rst_hit_q)
      |=> state_q == lpm_pkg::LPM_PDOWN)
    else $error("power-down left without a wake source");

  a_ext_wake_first: assert property (@(posedge clock) disable iff (!resetn) // RQ14
    (state_q == lpm_pkg::LPM_PDOWN && ext_wake && !rst_hit_q)
      |=> state_q == lpm_pkg::LPM_WAIT_EXT)
    else $error("external wake not taken");

  a_wake_clears_pd: assert property (@(posedge clock) disable iff (!resetn || reset_pin) // RQ13
    (state_q == lpm_pkg::LPM_PDOWN && (ext_wake || key_wake) && !mode_write && !rst_hit_q)
      |=> !powerdown_request_bit ##1 gate.osc_enable && gate.periph_clock_en)
    else $error("wake did not clear the request and restart clocks");

  a_ext_release_isr: assert property (@(posedge clock) disable iff (!resetn) // RQ16
    (state_q == lpm_pkg::LPM_WAIT_EXT && !ext_wake)
      |=> state_q == lpm_pkg::LPM_RUN && isr_request)
    else $error("release of external wake did not vector");

  a_isr_one_cycle: assert property (@(posedge clock) disable iff (!resetn) // RQ16
    isr_request |=> !isr_request)
    else $error("service request longer than one cycle");

  a_idle_periph_on: assert property (@(posedge clock) disable iff (!resetn) // RQ2
    state_q == lpm_pkg::LPM_IDLE |=> gate.periph_clock_en && !gate.cpu_clock_en)
    else $error("idle clocks wrong");

  a_pdown_cpu_off: assert property (@(posedge clock) disable iff (!resetn) // RQ10
    state_q == lpm_pkg::LPM_PDOWN |=> !gate.cpu_clock_en && gate.ram_access_en)
    else $error("cpu clock ran in power-down");

  a_key_wait_cpu_off: assert property (@(posedge clock) disable iff (!resetn) // RQ15
    state_q == lpm_pkg::LPM_WAIT_KEY |=> !gate.cpu_clock_en)
    else $error("cpu clock ran during keypad count");

  a_reset_to_resume: assert property (@(posedge clock) disable iff (!resetn) // RQ6
    (rst_hit_q && (state_q == lpm_pkg::LPM_IDLE || state_q == lpm_pkg::LPM_PDOWN))
      |=> state_q == lpm_pkg::LPM_RST_RESUME)
    else $error("reset pin did not start the resume window");

  a_resume_cpu_on: assert property (@(posedge clock) disable iff (!resetn) // RQ19
    $rose(state_q == lpm_pkg::LPM_RST_RESUME)
      |=> gate.cpu_clock_en && gate.osc_enable && gate.periph_clock_en)
    else $error("clocks not restored after reset pin");

  a_port_always: assert property (@(posedge clock) disable iff (!resetn) // RQ7
    gate.port_access_en)
    else $error("port access closed");

  a_sfr_with_takeover: assert property (@(posedge clock) disable iff (!resetn) // RQ21
    internal_reset |-> sfr_reset && !gate.ram_access_en)
    else $error("register reset not paired with takeover");

  a_takeover_one_cycle: assert property (@(posedge clock) disable iff (!resetn) // RQ20
    internal_reset |-> state_q == lpm_pkg::LPM_RUN ##1 !internal_reset)
    else $error("takeover pulse longer than one cycle");

  a_ram_open_run: assert property (@(posedge clock) disable iff (!resetn) // RQ22
    (state_q == lpm_pkg::LPM_RUN && $past(state_q) == lpm_pkg::LPM_RUN) |-> gate.ram_access_en)
    else $error("ram closed during normal running");

endmodule // lpm_ctrl
